/* File: verilog/addon_bm_pkg.sv */
/*
  constants for the add-on bus-master count and fifo status block.
  assumes a 32-bit add-on register port with byte addresses.
*/
package addon_bm_pkg;
  localparam logic [7:0] OFF_WRITE_COUNT = 8'h58;
  localparam logic [7:0] OFF_READ_COUNT  = 8'h5c;
  localparam logic [7:0] OFF_CTRL_STAT   = 8'h6c;
  localparam logic [31:0] COUNT_RESET    = 32'h00000000;
  localparam int BIT_WR_ZERO   = 7;
  localparam int BIT_RD_ZERO   = 6;
  localparam int BIT_IN_EMPTY  = 5;
  localparam int BIT_IN_FOUR   = 4;
  localparam int BIT_IN_FULL   = 3;
  localparam int BIT_OUT_EMPTY = 2;
  localparam int BIT_OUT_FOUR  = 1;
  localparam int BIT_OUT_FULL  = 0;
  localparam int BIT_COUNT_EN  = 28;
  localparam int BIT_OUT_RESET = 26;
  localparam int BIT_IN_RESET  = 25;
  localparam int FIFO_DEPTH    = 8;
  localparam int FOUR_LEVEL    = 4;
  localparam logic [31:0] WORD_BYTES = 32'h00000004;
  localparam logic [3:0] ALL_LANES    = 4'hf;
endpackage : addon_bm_pkg

/* File: verilog/addon_bus_master_count_status.sv */
/*
  add-on bus-master transfer counters and fifo occupancy flags.
  assumes the pci master engine reports one dword phase per strobe, synchronous to core_clk,
  and fifo push/pop strobes come from the datapath that owns the fifo storage.
*/
// How it works
// (R01) status bit 6 reads one when read count is zero, count enabled
// (R02) status bit 5 is one when inbound fifo is empty
// (R03) status bit 4 is one with four or more inbound free entries
// (R04) status bit 3 is one when inbound fifo is full
// (R05) status bit 2 is one when outbound fifo is empty
// (R06) status bit 1 is one with four or more outbound entries occupied
// (R07) status bit 0 is one when outbound fifo is full
// (R08) each master write phase lowers the write count until zero
// (R09) each master read phase lowers the read count until zero
// (R10) zero count stops the transfer and pulses a done event
// (R11) add-on loads each count in bytes, not dwords
// (R12) a non-multiple-of-four count ends with partial byte enables
// (R13) transfers start dword aligned; no alignment logic needed here
// (R14) count registers are reachable only while bit 28 is set
// (R15) status bit 7 reads one when write count is zero, count enabled
// (R16) control bit 28 makes the master honour the counters
// (R17) writing one to bit 26 resets outbound fifo flags, reads zero
// (R18) writing one to bit 25 resets inbound fifo flags, reads zero
// (R19) fifos are eight deep, flags update in the cycle after a push or pop
`timescale 1ns/10ps
module addon_bus_master_count_status #(
  parameter int DEPTH = addon_bm_pkg::FIFO_DEPTH
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  regAddr,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  input  wire logic [31:0] regWdata,
  output logic      [31:0] regRdata,
  input  wire logic        writePhase,
  input  wire logic        readPhase,
  input  wire logic        inPush,
  input  wire logic        inPop,
  input  wire logic        outPush,
  input  wire logic        outPop,
  output logic             writeStop,
  output logic             readStop,
  output logic             writeDone,
  output logic             readDone,
  output logic      [3:0]  writeLanes,
  output logic      [3:0]  readLanes,
  output logic             countEnable
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] FOUR_C = CW'(addon_bm_pkg::FOUR_LEVEL);

  logic [31:0]   wrCount_reg, wrCount_next, rdCount_reg, rdCount_next;
  logic          enable_reg, enable_next;
  logic [CW-1:0] inLevel_reg, inLevel_next, outLevel_reg, outLevel_next;
  logic [31:0]   rdata_reg, rdata_next;
  logic          wrStop_reg, wrStop_next, rdStop_reg, rdStop_next;
  logic          wrDone_reg, wrDone_next, rdDone_reg, rdDone_next;
  logic [3:0]    wrLanes_reg, wrLanes_next, rdLanes_reg, rdLanes_next;
  logic [7:0]    status;

  // bytes left before this phase; starts are dword aligned, so only the tail can be short [R13]
  function automatic logic [3:0] lanes_for(input logic [31:0] cnt);
    logic [3:0] l;
    l = addon_bm_pkg::ALL_LANES;
    if (cnt < addon_bm_pkg::WORD_BYTES)
    begin
      l = 4'((5'h01 << cnt[1:0]) - 5'h01); // [R12]
    end
    return l;
  endfunction : lanes_for

  // status byte from live state; counts flagged only when enabled
  always_comb
  begin
    status = 8'h00;
    status[addon_bm_pkg::BIT_WR_ZERO]   = enable_reg && (wrCount_reg == '0);      // [R15]
    status[addon_bm_pkg::BIT_RD_ZERO]   = enable_reg && (rdCount_reg == '0);      // [R01]
    status[addon_bm_pkg::BIT_IN_EMPTY]  = (inLevel_reg == '0);                    // [R02]
    status[addon_bm_pkg::BIT_IN_FOUR]   = (DEPTH_C - inLevel_reg) >= FOUR_C;      // [R03]
    status[addon_bm_pkg::BIT_IN_FULL]   = (inLevel_reg == DEPTH_C);               // [R04]
    status[addon_bm_pkg::BIT_OUT_EMPTY] = (outLevel_reg == '0);                   // [R05]
    status[addon_bm_pkg::BIT_OUT_FOUR]  = (outLevel_reg >= FOUR_C);               // [R06]
    status[addon_bm_pkg::BIT_OUT_FULL]  = (outLevel_reg == DEPTH_C);              // [R07]
  end

  // next state: register writes win over a decrement in the same cycle
  always_comb
  begin
    logic ctlHit;
    ctlHit = regWrite && (regAddr == addon_bm_pkg::OFF_CTRL_STAT);
    wrCount_next  = wrCount_reg;
    rdCount_next  = rdCount_reg;
    enable_next   = enable_reg;
    inLevel_next  = inLevel_reg;
    outLevel_next = outLevel_reg;
    wrDone_next   = 1'b0;
    rdDone_next   = 1'b0;
    wrLanes_next  = wrLanes_reg;
    rdLanes_next  = rdLanes_reg;
    if (ctlHit)
    begin
      enable_next = regWdata[addon_bm_pkg::BIT_COUNT_EN]; // [R16]
    end
    if (writePhase && enable_reg && wrCount_reg != '0)
    begin
      wrLanes_next = lanes_for(wrCount_reg);                                     // [R12]
      wrCount_next = (wrCount_reg < addon_bm_pkg::WORD_BYTES) ? '0 : wrCount_reg - addon_bm_pkg::WORD_BYTES; // [R08]
      wrDone_next  = (wrCount_next == '0);                                       // [R10]
    end
    if (readPhase && enable_reg && rdCount_reg != '0)
    begin
      rdLanes_next = lanes_for(rdCount_reg);                                     // [R12]
      rdCount_next = (rdCount_reg < addon_bm_pkg::WORD_BYTES) ? '0 : rdCount_reg - addon_bm_pkg::WORD_BYTES; // [R09]
      rdDone_next  = (rdCount_next == '0);                                       // [R10]
    end
    // byte counts loaded as written; blocked while counting is off
    if (regWrite && enable_reg && regAddr == addon_bm_pkg::OFF_WRITE_COUNT)
    begin
      wrCount_next = regWdata; // [R14] [R11]
    end
    if (regWrite && enable_reg && regAddr == addon_bm_pkg::OFF_READ_COUNT)
    begin
      rdCount_next = regWdata; // [R14] [R11]
    end
    inLevel_next  = inLevel_reg + CW'(inPush && !status[addon_bm_pkg::BIT_IN_FULL])
                    - CW'(inPop && inLevel_reg != '0); // [R19]
    outLevel_next = outLevel_reg + CW'(outPush && !status[addon_bm_pkg::BIT_OUT_FULL])
                    - CW'(outPop && outLevel_reg != '0); // [R19]
    if (ctlHit && regWdata[addon_bm_pkg::BIT_OUT_RESET])
    begin
      outLevel_next = '0; // [R17]
    end
    if (ctlHit && regWdata[addon_bm_pkg::BIT_IN_RESET])
    begin
      inLevel_next = '0; // [R18]
    end
    wrStop_next = enable_next && (wrCount_next == '0); // [R10]
    rdStop_next = enable_next && (rdCount_next == '0); // [R10]
    rdata_next = 32'h00000000;
    if (regRead)
    begin
      unique case (regAddr)
        addon_bm_pkg::OFF_WRITE_COUNT: rdata_next = enable_reg ? wrCount_reg : '0; // [R14]
        addon_bm_pkg::OFF_READ_COUNT:  rdata_next = enable_reg ? rdCount_reg : '0; // [R14]
        addon_bm_pkg::OFF_CTRL_STAT:
        begin
          rdata_next = {24'h000000, status}; // pulse bits 26/25 read zero [R17] [R18]
          rdata_next[addon_bm_pkg::BIT_COUNT_EN] = enable_reg;
        end
        default:                       rdata_next = 32'h00000000;
      endcase
    end
  end

  // register stage; outputs come straight from these flops
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      wrCount_reg  <= addon_bm_pkg::COUNT_RESET;
      rdCount_reg  <= addon_bm_pkg::COUNT_RESET;
      enable_reg   <= 1'b0;
      inLevel_reg  <= '0;
      outLevel_reg <= '0;
      rdata_reg    <= 32'h00000000;
      wrStop_reg   <= 1'b0;
      rdStop_reg   <= 1'b0;
      wrDone_reg   <= 1'b0;
      rdDone_reg   <= 1'b0;
      wrLanes_reg  <= addon_bm_pkg::ALL_LANES;
      rdLanes_reg  <= addon_bm_pkg::ALL_LANES;
    end
    else
    begin
      wrCount_reg  <= wrCount_next;
      rdCount_reg  <= rdCount_next;
      enable_reg   <= enable_next;
      inLevel_reg  <= inLevel_next;
      outLevel_reg <= outLevel_next;
      rdata_reg    <= rdata_next;
      wrStop_reg   <= wrStop_next;
      rdStop_reg   <= rdStop_next;
      wrDone_reg   <= wrDone_next;
      rdDone_reg   <= rdDone_next;
      wrLanes_reg  <= wrLanes_next;
      rdLanes_reg  <= rdLanes_next;
    end
  end

  assign regRdata    = rdata_reg;
  assign writeStop   = wrStop_reg;
  assign readStop    = rdStop_reg;
  assign writeDone   = wrDone_reg;
  assign readDone    = rdDone_reg;
  assign writeLanes  = wrLanes_reg;
  assign readLanes   = rdLanes_reg;
  assign countEnable = enable_reg;

  sequence s_wrLast;
    writePhase && enable_reg && wrCount_reg != '0 && wrCount_reg <= addon_bm_pkg::WORD_BYTES && !regWrite;
  endsequence
  sequence s_rdLast;
    readPhase && enable_reg && rdCount_reg != '0 && rdCount_reg <= addon_bm_pkg::WORD_BYTES && !regWrite;
  endsequence

  property p_wrDec;
    @(posedge core_clk) disable iff (reset)
    writePhase && enable_reg && wrCount_reg > addon_bm_pkg::WORD_BYTES && !regWrite
      |=> wrCount_reg == $past(wrCount_reg) - addon_bm_pkg::WORD_BYTES;
  endproperty
  a_wrDec: assert property (p_wrDec) else $error("write count did not drop by four"); // [R08]
  property p_rdDec;
    @(posedge core_clk) disable iff (reset)
    readPhase && enable_reg && rdCount_reg > addon_bm_pkg::WORD_BYTES && !regWrite
      |=> rdCount_reg == $past(rdCount_reg) - addon_bm_pkg::WORD_BYTES;
  endproperty
  a_rdDec: assert property (p_rdDec) else $error("read count did not drop by four"); // [R09]
  property p_wrEnd;
    @(posedge core_clk) disable iff (reset)
    s_wrLast |=> writeDone && writeStop && wrCount_reg == '0;
  endproperty
  a_wrEnd: assert property (p_wrEnd) else $error("write transfer did not stop at zero"); // [R10]
  property p_rdEnd;
    @(posedge core_clk) disable iff (reset)
    s_rdLast |=> readDone && readStop && rdCount_reg == '0;
  endproperty
  a_rdEnd: assert property (p_rdEnd) else $error("read transfer did not stop at zero"); // [R10]
  property p_tail;
    @(posedge core_clk) disable iff (reset)
    writePhase && enable_reg && wrCount_reg == 32'h00000003 |=> writeLanes == 4'h7;
  endproperty
  a_tail: assert property (p_tail) else $error("partial tail lanes wrong"); // [R12]
  property p_lock;
    @(posedge core_clk) disable iff (reset)
    !enable_reg && !writePhase |=> $stable(wrCount_reg);
  endproperty
  a_lock: assert property (p_lock) else $error("count changed while disabled"); // [R14]
  property p_inRst;
    @(posedge core_clk) disable iff (reset)
    regWrite && regAddr == addon_bm_pkg::OFF_CTRL_STAT && regWdata[addon_bm_pkg::BIT_IN_RESET]
      |=> status[addon_bm_pkg::BIT_IN_EMPTY] && status[addon_bm_pkg::BIT_IN_FOUR]
          && !status[addon_bm_pkg::BIT_IN_FULL];
  endproperty
  a_inRst: assert property (p_inRst) else $error("inbound flag reset failed"); // [R18]
  property p_outRst;
    @(posedge core_clk) disable iff (reset)
    regWrite && regAddr == addon_bm_pkg::OFF_CTRL_STAT && regWdata[addon_bm_pkg::BIT_OUT_RESET]
      |=> status[addon_bm_pkg::BIT_OUT_EMPTY] && !status[addon_bm_pkg::BIT_OUT_FOUR]
          && !status[addon_bm_pkg::BIT_OUT_FULL];
  endproperty
  a_outRst: assert property (p_outRst) else $error("outbound flag reset failed"); // [R17]
  property p_outPush;
    @(posedge core_clk) disable iff (reset)
    outPush && !outPop && outLevel_reg == '0 && !regWrite |=> !status[addon_bm_pkg::BIT_OUT_EMPTY];
  endproperty
  a_outPush: assert property (p_outPush) else $error("outbound empty not cleared by push"); // [R19]
endmodule : addon_bus_master_count_status

/* File: test/master_phase_model.sv */
/*
  partner model: the pci master engine of one direction, issuing dword phases.
  assumes core_clk and the block's stop level; the bench raises go after loading a count.
*/
`timescale 1ns/10ps
module master_phase_model (
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic       stop,
  output logic            phase,
  output logic [7:0]      phaseCnt
);
  logic [1:0] gapReg = 2'h0;

  // one pulse then a gap, so no pulse can land after the stop edge; slow mode spaces them by four
  always_ff @(posedge core_clk)
  begin
    gapReg <= gapReg + 2'h1;
    phase  <= go && !stop && !phase && (!slow || gapReg == 2'h3);
    if (!go)
      phaseCnt <= 8'h00;
    else if (phase)
      phaseCnt <= phaseCnt + 8'h01;
  end
endmodule : master_phase_model

/* File: test/addon_bus_master_count_status_tb.sv */
/*
  testbench for the add-on bus-master counters and fifo status flags.
  assumes the design package and the phase model are compiled before it.
*/
`timescale 1ns/10ps
module addon_bus_master_count_status_tb;
  localparam int D = addon_bm_pkg::FIFO_DEPTH;
  logic        core_clk = 1'h0, reset = 1'h1, regWrite = 1'h0, regRead = 1'h0, rdSeen = 1'h0;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, regRdata, rnd = 32'hfb24;
  logic        inPush = 1'h0, inPop = 1'h0, outPush = 1'h0, outPop = 1'h0, wGo = 1'h0, rGo = 1'h0, slow = 1'h0;
  logic        writePhase, readPhase, writeStop, readStop, writeDone, readDone, countEnable;
  logic [3:0]  writeLanes, readLanes;
  logic [7:0]  wCnt, rCnt;
  logic [31:0] expQ[$];
  int          errorCnt = 0, samplesChecked = 0, cycles = 0, inOcc = 0, outOcc = 0;

  addon_bus_master_count_status #(.DEPTH(D)) DUT (
    .core_clk(core_clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata), .writePhase(writePhase), .readPhase(readPhase),
    .inPush(inPush), .inPop(inPop), .outPush(outPush), .outPop(outPop), .writeStop(writeStop),
    .readStop(readStop), .writeDone(writeDone), .readDone(readDone), .writeLanes(writeLanes),
    .readLanes(readLanes), .countEnable(countEnable));
  master_phase_model WPM (.core_clk(core_clk), .go(wGo), .slow(slow), .stop(writeStop), .phase(writePhase),
    .phaseCnt(wCnt));
  master_phase_model RPM (.core_clk(core_clk), .go(rGo), .slow(slow), .stop(readStop), .phase(readPhase),
    .phaseCnt(rCnt));

  // 10 MHz clock and a cycle ceiling well above the longest expected run
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errorCnt++;
      final_report();
    end
  end

  // read data is registered, so the oldest note is compared one cycle after the strobe
  always @(posedge core_clk) rdSeen <= regRead;
  always @(negedge core_clk)
    if (rdSeen)
      chk(regRdata, expQ.pop_front());

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("errors=%0d checks=%0d", errorCnt, samplesChecked);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  endfunction : xs

  // expected status word from the bench's own occupancy model
  function automatic logic [31:0] stat(input logic en, input logic wz, input logic rz);
    stat = {3'h0, en, 20'h0, en & wz, en & rz, inOcc == 0, D - inOcc >= 4, inOcc == D,
            outOcc == 0, outOcc >= 4, outOcc == D};
  endfunction : stat

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWdata = d;
    regWrite = 1'h1;
    @(negedge core_clk);
    regWrite = 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(negedge core_clk);
    regAddr = a;
    regRead = 1'h1;
    expQ.push_back(e);
    @(negedge core_clk);
    regRead = 1'h0;
  endtask : rd

  // load a byte count, let the engine run, then idle to catch phases issued after the stop
  task automatic xfer(input logic rdDir, input logic [31:0] n);
    int k;
    logic [3:0] lanes;
    lanes = (n[1:0] == 2'h0) ? 4'hf : 4'hf >> (3'h4 - {1'h0, n[1:0]});
    k = 0;
    wr(rdDir ? 8'h5c : 8'h58, n);
    rGo = rdDir;
    wGo = !rdDir;
    while ((rdDir ? readDone : writeDone) !== 1'h1 && k < 400)
    begin
      @(negedge core_clk);
      k++;
    end
    repeat (6) @(negedge core_clk);
    chk(k < 400, 32'h1);
    chk(rdDir ? {readDone, readStop, rCnt, readLanes} : {writeDone, writeStop, wCnt, writeLanes},
        {2'h1, 8'((n + 32'h3) >> 2), lanes});
    rGo = 1'h0;
    wGo = 1'h0;
    rd(rdDir ? 8'h5c : 8'h58, 32'h0);
  endtask : xfer

  initial
  begin
    repeat (12) @(negedge core_clk);
    reset = 1'h0;
    chk({writeStop, readStop, countEnable, writeLanes}, {3'h0, 4'hf});
    rd(8'h6c, stat(1'h0, 1'h1, 1'h1));
    wr(8'h58, 32'h10);
    rd(8'h58, 32'h0);
    wr(8'h6c, 32'h10000000);
    chk(countEnable, 32'h1);
    rd(8'h58, 32'h0);
    rd(8'h6c, stat(1'h1, 1'h1, 1'h1));
    for (int i = 0; i < 8; i++)
    begin
      rnd = xs(rnd);
      slow = rnd[4];
      xfer(i > 3, 32'(i % 4 + 1 + (i > 3 ? 4 * rnd[3:0] : 0)));
    end
    // fill both fifos past full, flag-reset them, then drain past empty
    for (int i = 0; i < 60; i++)
    begin
      if (i == 30)
      begin
        wr(8'h6c, 32'h16000000);
        inOcc = 0;
        outOcc = 0;
      end
      rnd = xs(rnd);
      @(negedge core_clk);
      inPush = (rnd[1:0] != 2'h0) ^ (i >= 30);
      inPop = !inPush;
      outPush = (rnd[3:2] != 2'h0) ^ (i >= 30);
      outPop = !outPush;
      @(negedge core_clk);
      inOcc = inPush ? inOcc + (inOcc < D) : inOcc - (inOcc > 0);
      outOcc = outPush ? outOcc + (outOcc < D) : outOcc - (outOcc > 0);
      {inPush, inPop, outPush, outPop} = 4'h0;
      rd(8'h6c, stat(1'h1, 1'h1, 1'h1));
    end
    // counting off: phases must leave a loaded count alone, and stop must stay low
    wr(8'h58, 32'h8);
    wr(8'h6c, 32'h0);
    wGo = 1'h1;
    repeat (8) @(negedge core_clk);
    chk({writeStop, writeDone, countEnable}, 32'h0);
    wGo = 1'h0;
    wr(8'h6c, 32'h10000000);
    rd(8'h58, 32'h8);
    final_report();
  end
endmodule : addon_bus_master_count_status_tb
